// ### fsq_pkg.sv
// Constants, command codes and instruction decode for the flash host sequencer
package fsq_pkg;

  // Timing
  localparam int CLK_NS       = 5;
  localparam int WR_PULSE_NS  = 45;
  localparam int RD_ACCESS_NS = 90;
  localparam int WR_CYC       = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC       = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 5;
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);

  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LOW_W  = 12;
  localparam int PSEL_W = 8;
  localparam int SSEL_W = 4;

  // Coded cycles and instruction bytes
  localparam logic [LOW_W-1:0]  UNLOCK1_ADDR    = 12'hAAA;
  localparam logic [LOW_W-1:0]  UNLOCK2_ADDR    = 12'h554;
  localparam logic [BYTE_W-1:0] UNLOCK1_DATA    = 8'hAA;
  localparam logic [BYTE_W-1:0] UNLOCK2_DATA    = 8'h55;
  localparam logic [BYTE_W-1:0] OP_AUTOSELECT   = 8'h90;
  localparam logic [BYTE_W-1:0] OP_PROGRAM      = 8'hA0;
  localparam logic [BYTE_W-1:0] OP_ERASE_SETUP  = 8'h80;
  localparam logic [BYTE_W-1:0] OP_SECTOR_ERASE = 8'h30;
  localparam logic [BYTE_W-1:0] OP_BULK_ERASE   = 8'h10;
  localparam logic [BYTE_W-1:0] OP_RESET        = 8'hF0;
  localparam logic [BYTE_W-1:0] ID_LOW          = 8'h02;
  localparam logic [BYTE_W-1:0] PROT_LOW        = 8'h04;

  // Status bit positions
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT  = 5;
  localparam int WINDOW_BIT = 3;

  // Instruction step numbers
  localparam int STEP_W = 3;
  localparam logic [STEP_W-1:0] STEP_U1   = 3'h0;
  localparam logic [STEP_W-1:0] STEP_U2   = 3'h1;
  localparam logic [STEP_W-1:0] STEP_OP   = 3'h2;
  localparam logic [STEP_W-1:0] STEP_U3   = 3'h3;
  localparam logic [STEP_W-1:0] STEP_U4   = 3'h4;
  localparam logic [STEP_W-1:0] STEP_CONF = 3'h5;
  localparam logic [STEP_W-1:0] LEN_ONE   = 3'h1;
  localparam logic [STEP_W-1:0] LEN_FOUR  = 3'h4;
  localparam logic [STEP_W-1:0] LEN_SIX   = 3'h6;

  typedef enum logic [2:0] {
    CMD_READ   = 3'b000,
    CMD_ID     = 3'b001,
    CMD_PROT   = 3'b010,
    CMD_PROG   = 3'b011,
    CMD_SERASE = 3'b100,
    CMD_BERASE = 3'b101,
    CMD_RESET  = 3'b110
  } fsq_cmd_e;

  function automatic logic [STEP_W-1:0] seq_len(input fsq_cmd_e cmd);
    case (cmd)
      CMD_READ, CMD_RESET:   seq_len = LEN_ONE;
      CMD_SERASE, CMD_BERASE: seq_len = LEN_SIX;
      default:               seq_len = LEN_FOUR;
    endcase
  endfunction : seq_len

  function automatic logic step_read(input fsq_cmd_e cmd, input logic [STEP_W-1:0] step);
    step_read = (cmd == CMD_READ) || ((cmd == CMD_ID || cmd == CMD_PROT) && step == STEP_U3);
  endfunction : step_read

  function automatic logic [ADDR_W-1:0] step_addr(input fsq_cmd_e cmd,
                                                  input logic [STEP_W-1:0] step,
                                                  input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-LOW_W-1:0] hi;
    hi = addr[ADDR_W-1:LOW_W];
    if (cmd == CMD_READ || cmd == CMD_RESET ||
        (cmd == CMD_PROG && step == STEP_U3) || (cmd == CMD_SERASE && step == STEP_CONF))
      step_addr = addr;
    else if (cmd == CMD_ID && step == STEP_U3)
      step_addr = {addr[ADDR_W-1:BYTE_W], ID_LOW};
    else if (cmd == CMD_PROT && step == STEP_U3)
      step_addr = {addr[ADDR_W-1:BYTE_W], PROT_LOW};
    else if (step == STEP_U2 || step == STEP_U4)
      step_addr = {hi, UNLOCK2_ADDR};
    else
      step_addr = {hi, UNLOCK1_ADDR};
  endfunction : step_addr

  function automatic logic [BYTE_W-1:0] step_byte(input fsq_cmd_e cmd,
                                                  input logic [STEP_W-1:0] step);
    if (cmd == CMD_RESET)
      step_byte = OP_RESET;
    else if (step == STEP_U2 || step == STEP_U4)
      step_byte = UNLOCK2_DATA;
    else if (step == STEP_OP)
      step_byte = (cmd == CMD_PROG) ? OP_PROGRAM :
                  (cmd == CMD_SERASE || cmd == CMD_BERASE) ? OP_ERASE_SETUP : OP_AUTOSELECT;
    else if (step == STEP_CONF)
      step_byte = (cmd == CMD_SERASE) ? OP_SECTOR_ERASE : OP_BULK_ERASE;
    else
      step_byte = UNLOCK1_DATA;
  endfunction : step_byte

  function automatic logic [BYTE_W-1:0] status_byte(input logic [DATA_W-1:0] word,
                                                    input logic be);
    status_byte = be ? word[DATA_W-1:BYTE_W] : word[BYTE_W-1:0];
  endfunction : status_byte

endpackage : fsq_pkg

// ### fsq_bus_cycle.sv
// One timed read or write cycle on the flash pins
`timescale 1ns/1ps
module fsq_bus_cycle
  import fsq_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // Request
  input  wire logic              start_in,
  input  wire logic              write_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [PSEL_W-1:0] psel_in,
  input  wire logic [SSEL_W-1:0] ssel_in,
  output logic                   done_out,
  output logic      [DATA_W-1:0] rdata_out,
  // Flash pins
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_out,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   low_byte_write_strobe_n_out,
  output logic                   read_strobe_n_out,
  output logic      [PSEL_W-1:0] primary_sector_selects_out,
  output logic      [SSEL_W-1:0] secondary_sector_selects_out
);

  typedef enum logic [1:0] {
    B_IDLE   = 2'b00,
    B_SETUP  = 2'b01,
    B_STROBE = 2'b10,
    B_HOLD   = 2'b11
  } fsq_bus_e;

  fsq_bus_e         state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             write_r;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // Selects low and strobes high while held in reset
      state_r                      <= B_IDLE;
      cnt_r                        <= '0;
      write_r                      <= 1'b0;
      done_out                     <= 1'b0;
      rdata_out                    <= '0;
      addr_out                     <= '0;
      dq_out                       <= '0;
      dq_oe_out                    <= 1'b0;
      low_byte_write_strobe_n_out  <= 1'b1;
      read_strobe_n_out            <= 1'b1;
      primary_sector_selects_out   <= '0;
      secondary_sector_selects_out <= '0;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        B_IDLE: begin
          if (start_in) begin
            // Address and selects settle a cycle before the strobe falls
            state_r                      <= B_SETUP;
            write_r                      <= write_in;
            addr_out                     <= addr_in;
            dq_out                       <= wdata_in;
            dq_oe_out                    <= write_in;
            primary_sector_selects_out   <= psel_in;
            secondary_sector_selects_out <= ssel_in;
          end
        end
        B_SETUP: begin
          state_r <= B_STROBE;
          cnt_r   <= write_r ? WR_CNT : RD_CNT;
          if (write_r)
            low_byte_write_strobe_n_out <= 1'b0;
          else
            read_strobe_n_out <= 1'b0;
        end
        B_STROBE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CNT_W'(LEN_ONE)) begin
            state_r                     <= B_HOLD;
            low_byte_write_strobe_n_out <= 1'b1;
            read_strobe_n_out           <= 1'b1;
            if (!write_r)
              rdata_out <= dq_in;
          end
        end
        B_HOLD: begin
          // Data held past the rising strobe, then bus released
          state_r                      <= B_IDLE;
          dq_oe_out                    <= 1'b0;
          primary_sector_selects_out   <= '0;
          secondary_sector_selects_out <= '0;
          done_out                     <= 1'b1;
        end
        default: state_r <= B_IDLE;
      endcase
    end
  end

  chk_reset_pins_quiet: assert property (@(posedge core_clk_in)
    rst_in |=> (low_byte_write_strobe_n_out && primary_sector_selects_out == '0 &&
                secondary_sector_selects_out == '0))
    else $error("pins not quiet after reset");

  chk_strobe_min_width: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(low_byte_write_strobe_n_out) |-> !low_byte_write_strobe_n_out[*8])
    else $error("write strobe too short");

endmodule : fsq_bus_cycle

// ### fsq_flash_host.sv
// Host sequencer issuing flash instructions and polling embedded status
`timescale 1ns/1ps
// How it works
// - Host holds all sector selects low and write strobe high at power-up.
// - Poll valid after fourth or sixth write; host polls target or sector.
// - Host treats operation as done when two reads give the same toggle bit (bit 6).
// - Only reset clears error; host issues reset after seeing the error.
// - Instructions other than read and reset open with AAh at XAAAh then 55h at X554h.
module fsq_flash_host
  import fsq_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // User command port
  input  wire logic              cmd_valid_in,
  input  wire logic [2:0]        cmd_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [PSEL_W-1:0] psel_in,
  input  wire logic [SSEL_W-1:0] ssel_in,
  input  wire logic              be_mode_in,
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   error_out,
  output logic      [DATA_W-1:0] rdata_out,
  output logic      [BYTE_W-1:0] status_out,
  // Flash pins
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_out,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   low_byte_write_strobe_n_out,
  output logic                   read_strobe_n_out,
  output logic      [PSEL_W-1:0] primary_sector_selects_out,
  output logic      [SSEL_W-1:0] secondary_sector_selects_out
);

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SEQ    = 3'b001,
    S_POLL   = 3'b010,
    S_RECOV  = 3'b011,
    S_FINISH = 3'b100
  } fsq_state_e;

  fsq_state_e        state_r;
  fsq_cmd_e          cmd_r;
  logic [STEP_W-1:0] step_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [PSEL_W-1:0] psel_r;
  logic [SSEL_W-1:0] ssel_r;
  logic              be_r;
  logic              cyc_start_r;
  logic              cyc_write_r;
  logic [ADDR_W-1:0] cyc_addr_r;
  logic [DATA_W-1:0] cyc_data_r;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic              second_r;
  logic              err_check_r;
  logic              err_flag_r;
  logic [BYTE_W-1:0] first_sts_r;
  logic [BYTE_W-1:0] sts;
  logic [STEP_W-1:0] step_nxt;
  logic              last_step;
  logic              toggle_same;

  assign sts         = status_byte(cyc_rdata, be_r);
  assign last_step   = (step_r == seq_len(cmd_r) - LEN_ONE);
  assign step_nxt    = step_r + LEN_ONE;
  assign toggle_same = (sts[TOGGLE_BIT] == first_sts_r[TOGGLE_BIT]);

  // Sequencer and cycle requests
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r     <= S_IDLE;
      cmd_r       <= CMD_READ;
      step_r      <= '0;
      addr_r      <= '0;
      wdata_r     <= '0;
      psel_r      <= '0;
      ssel_r      <= '0;
      be_r        <= 1'b0;
      cyc_start_r <= 1'b0;
      cyc_write_r <= 1'b0;
      cyc_addr_r  <= '0;
      cyc_data_r  <= '0;
      second_r    <= 1'b0;
      err_check_r <= 1'b0;
      err_flag_r  <= 1'b0;
      first_sts_r <= '0;
    end else begin
      cyc_start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_valid_in) begin
            state_r     <= S_SEQ;
            cmd_r       <= fsq_cmd_e'(cmd_in);
            step_r      <= STEP_U1;
            addr_r      <= addr_in;
            wdata_r     <= wdata_in;
            psel_r      <= psel_in;
            ssel_r      <= ssel_in;
            be_r        <= be_mode_in;
            err_flag_r  <= 1'b0;
            cyc_start_r <= 1'b1;
            cyc_write_r <= !step_read(fsq_cmd_e'(cmd_in), STEP_U1);
            // Upper address bits ride along; only the low twelve are decoded
            cyc_addr_r  <= step_addr(fsq_cmd_e'(cmd_in), STEP_U1, addr_in);
            cyc_data_r  <= {2{step_byte(fsq_cmd_e'(cmd_in), STEP_U1)}};
          end
        end
        S_SEQ: begin
          if (cyc_done) begin
            if (!last_step) begin
              step_r      <= step_nxt;
              cyc_start_r <= 1'b1;
              cyc_write_r <= !step_read(cmd_r, step_nxt);
              cyc_addr_r  <= step_addr(cmd_r, step_nxt, addr_r);
              cyc_data_r  <= (cmd_r == CMD_PROG && step_nxt == STEP_U3) ?
                             wdata_r : {2{step_byte(cmd_r, step_nxt)}};
            end else if (cmd_r == CMD_PROG || cmd_r == CMD_SERASE || cmd_r == CMD_BERASE) begin
              // Status only meaningful once the final write pulse is done
              state_r     <= S_POLL;
              second_r    <= 1'b0;
              err_check_r <= 1'b0;
              cyc_start_r <= 1'b1;
              cyc_write_r <= 1'b0;
              cyc_addr_r  <= addr_r;
            end else begin
              state_r <= S_FINISH;
            end
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            cyc_start_r <= 1'b1;
            cyc_write_r <= 1'b0;
            cyc_addr_r  <= addr_r;
            second_r    <= !second_r;
            first_sts_r <= sts;
            if (second_r) begin
              if (toggle_same) begin
                // Two matching reads mean the embedded cycle has ended
                state_r     <= S_FINISH;
                cyc_start_r <= 1'b0;
              end else if (err_check_r) begin
                // Still toggling after the error bit: failed, recover with reset
                state_r     <= S_RECOV;
                err_flag_r  <= 1'b1;
                cyc_write_r <= 1'b1;
                cyc_data_r  <= {2{OP_RESET}};
              end else if (sts[ERROR_BIT]) begin
                // Toggle may change with the error bit, so check once more
                err_check_r <= 1'b1;
              end
            end
          end
        end
        S_RECOV: begin
          if (cyc_done)
            state_r <= S_FINISH;
        end
        S_FINISH: state_r <= S_IDLE;
        default:  state_r <= S_IDLE;
      endcase
    end
  end

  // User results
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      error_out  <= 1'b0;
      rdata_out  <= '0;
      status_out <= '0;
    end else begin
      busy_out <= (state_r != S_IDLE) || cmd_valid_in;
      done_out <= (state_r == S_FINISH);
      if (state_r == S_FINISH)
        error_out <= err_flag_r;
      if (cyc_done && !cyc_write_r) begin
        rdata_out  <= cyc_rdata;
        status_out <= sts;
      end
    end
  end

  fsq_bus_cycle u_cycle (
    .core_clk_in                  (core_clk_in),
    .rst_in                       (rst_in),
    .start_in                     (cyc_start_r),
    .write_in                     (cyc_write_r),
    .addr_in                      (cyc_addr_r),
    .wdata_in                     (cyc_data_r),
    .psel_in                      (psel_r),
    .ssel_in                      (ssel_r),
    .done_out                     (cyc_done),
    .rdata_out                    (cyc_rdata),
    .addr_out                     (addr_out),
    .dq_out                       (dq_out),
    .dq_oe_out                    (dq_oe_out),
    .dq_in                        (dq_in),
    .low_byte_write_strobe_n_out  (low_byte_write_strobe_n_out),
    .read_strobe_n_out            (read_strobe_n_out),
    .primary_sector_selects_out   (primary_sector_selects_out),
    .secondary_sector_selects_out (secondary_sector_selects_out)
  );

  chk_first_coded_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cyc_start_r && state_r == S_SEQ && step_r == STEP_U1 && cmd_r != CMD_READ &&
     cmd_r != CMD_RESET) |-> (cyc_addr_r[LOW_W-1:0] == UNLOCK1_ADDR &&
                              cyc_data_r[BYTE_W-1:0] == UNLOCK1_DATA))
    else $error("first coded write wrong");

  chk_second_coded_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cyc_start_r && step_r == STEP_U2 && state_r == S_SEQ) |->
    (cyc_addr_r[LOW_W-1:0] == UNLOCK2_ADDR && cyc_data_r[BYTE_W-1:0] == UNLOCK2_DATA))
    else $error("second coded write wrong");

  chk_upper_bits_kept: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cyc_start_r && state_r == S_SEQ) |->
    cyc_addr_r[ADDR_W-1:LOW_W] == addr_r[ADDR_W-1:LOW_W])
    else $error("upper address bits altered");

  chk_poll_target_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (cyc_start_r && state_r == S_POLL) |-> (!cyc_write_r && cyc_addr_r == addr_r))
    else $error("poll read at wrong address");

  chk_poll_after_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == S_SEQ && cyc_done && last_step && cmd_r == CMD_PROG) |=>
    (state_r == S_POLL && cyc_start_r))
    else $error("no poll after program");

  chk_done_on_match: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == S_POLL && cyc_done && second_r && toggle_same) |=> ##1 done_out)
    else $error("matching reads did not finish");

  chk_reset_after_error: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(err_flag_r) |-> (cyc_start_r && cyc_write_r && cyc_data_r[BYTE_W-1:0] == OP_RESET)
    ##[1:40] (state_r == S_FINISH))
    else $error("error not followed by reset write");

  chk_no_early_finish: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == S_POLL && cyc_done && !second_r) |=> state_r == S_POLL)
    else $error("finished on a single read");

endmodule : fsq_flash_host

// ### fsq_flash_model.sv
// Behavioural flash device answering the host sequencer
`timescale 1ns/1ps
module fsq_flash_model
  import fsq_pkg::*;
#(
  parameter logic [7:0] ID_CODE   = 8'h5A, // Arbitrary value
  parameter logic [7:0] PROT_MASK = 8'h80
) (
  // Host pins
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              low_byte_write_strobe_n_in,
  input  wire logic              read_strobe_n_in,
  input  wire logic [PSEL_W-1:0] psel_in,
  input  wire logic              be_in,
  output logic      [DATA_W-1:0] dq_out
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] tgt = 16'h0000;
  logic [7:0]        st, b;
  logic              tog = 1'b0, err = 1'b0, ers = 1'b0, win = 1'b1, prot, pe = 1'b0;
  int                step = 0, mode = 0, left = 0;

  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
  endfunction : rd

  initial dq_out = 16'h0000;

  // No select, no decode: the strobe's first edge out of reset is not a write
  always @(posedge low_byte_write_strobe_n_in) if (|psel_in) begin
    b = dq_in[7:0];
    prot = |(psel_in & PROT_MASK);
    if (step == 3) begin
      step = 0;
      tgt = dq_in;
      ers = 1'b0;
      pe = 1'b0;
      err = !prot && |(~rd(addr_in) & dq_in);
      mode = prot ? 0 : 2;
      left = 4;
      if (!prot && !err)
        mem[int'(addr_in)] = dq_in;
    end else if (b == OP_RESET) begin
      step = 0;
      mode = 0;
      err = 1'b0;
    end else if (step == 0 || step == 4)
      step = (addr_in[11:0] == UNLOCK1_ADDR && b == UNLOCK1_DATA) ? step + 1 : 0;
    else if (step == 1 || step == 5)
      step = (addr_in[11:0] == UNLOCK2_ADDR && b == UNLOCK2_DATA) ? step + 1 : 0;
    else if (step == 2) begin
      mode = (b == OP_AUTOSELECT) ? 1 : 0;
      step = (b == OP_PROGRAM) ? 3 : (b == OP_ERASE_SETUP) ? 4 : 0;
    end else begin
      step = 0;
      ers = 1'b1;
      win = (b != OP_SECTOR_ERASE);
      mode = 2;
      // Fully protected erase: one quiet pair of reads, nothing erased
      pe = prot;
      left = prot ? 2 : 4;
      if (!prot)
        mem.delete();
    end
  end

  always @(negedge read_strobe_n_in) begin
    if (mode == 2) begin
      st = {!ers && !(be_in ? tgt[15] : tgt[7]), tog && !pe, err, 1'b0, win, 3'b000};
      tog = ~tog;
      win = 1'b1;
      left = err ? left : left - 1;
      mode = (left == 0) ? 0 : 2;
      dq_out = be_in ? {st, ~st} : {~st, st};
    end else if (mode == 1)
      dq_out = (addr_in[7:0] == ID_LOW && |psel_in) ? {8'h00, ID_CODE}
                                                    : {15'h0, |(psel_in & PROT_MASK)};
    else
      dq_out = rd(addr_in);
  end

  // Released bus must not keep the last word
  always @(posedge read_strobe_n_in)
    #2 dq_out = ~dq_out;
endmodule : fsq_flash_model

// ### fsq_flash_host_tb.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module fsq_flash_host_tb
  import fsq_pkg::*;
;
  localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary value
  localparam logic [7:0] PMASK  = 8'h80;
  logic              core_clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0;
  logic              be_mode_in = 1'b0, be_nxt = 1'b0;
  logic [2:0]        cmd_in = 3'h0;
  logic [ADDR_W-1:0] addr_in = 16'h0000, addr_out, a;
  logic [DATA_W-1:0] wdata_in = 16'h0000, dq_out, dq_in, dev_dq, rdata_out, d;
  logic [PSEL_W-1:0] psel_in = 8'h00, psel_out;
  logic [SSEL_W-1:0] ssel_in = 4'h0, ssel_out;
  logic [BYTE_W-1:0] status_out;
  logic              busy_out, done_out, error_out, dq_oe_out, wr_n, rd_n;
  logic [DATA_W-1:0] ref_mem [int];
  int                fails = 0, tests_run = 0;

  always #2.5 core_clk_in = ~core_clk_in;
  assign dq_in = dq_oe_out ? dq_out : dev_dq;

  fsq_flash_host i_dut (.core_clk_in, .rst_in, .cmd_valid_in, .cmd_in, .addr_in, .wdata_in,
    .psel_in, .ssel_in, .be_mode_in, .busy_out, .done_out, .error_out, .rdata_out,
    .status_out, .addr_out, .dq_out, .dq_oe_out, .dq_in, .low_byte_write_strobe_n_out(wr_n),
    .read_strobe_n_out(rd_n), .primary_sector_selects_out(psel_out),
    .secondary_sector_selects_out(ssel_out));
  fsq_flash_model #(.ID_CODE(ID_VAL), .PROT_MASK(PMASK)) i_dev (.addr_in(addr_out), .dq_in,
    .low_byte_write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .psel_in(psel_out),
    .be_in(be_mode_in), .dq_out(dev_dq));

  function automatic logic [DATA_W-1:0] expv(input logic [ADDR_W-1:0] x);
    return ref_mem.exists(int'(x)) ? ref_mem[int'(x)] : 16'hFFFF;
  endfunction : expv

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic run(input fsq_cmd_e c, input logic [ADDR_W-1:0] x,
                     input logic [DATA_W-1:0] w, input logic [PSEL_W-1:0] ps);
    int n;
    n = 0;
    @(negedge core_clk_in);
    cmd_in = c;
    addr_in = x;
    wdata_in = w;
    psel_in = ps;
    be_mode_in = be_nxt;
    cmd_valid_in = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    check(busy_out === 1'b1, "not busy after request");
    while (done_out !== 1'b1) begin
      @(posedge core_clk_in);
      #1;
      if (++n > 5000) begin
        check(1'b0, "no completion");
        wrap_up();
      end
    end
  endtask : run

  // Reference decides the flag from the old cell contents
  task automatic prog_chk(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] w,
                          input logic [PSEL_W-1:0] ps);
    logic p, e;
    p = |(ps & PMASK);
    e = !p && |(~expv(x) & w);
    run(CMD_PROG, x, w, ps);
    check(error_out === e, "program flag");
    if (e)
      check(status_out[ERROR_BIT] === 1'b1, "status error bit");
    if (!e && !p)
      ref_mem[int'(x)] = w;
    run(CMD_READ, x, 16'h0000, 8'h01);
    check(rdata_out === expv(x) && error_out === 1'b0, "read back");
  endtask : prog_chk

  initial begin
    void'($urandom(96));
    repeat (8) @(negedge core_clk_in);
    check(wr_n === 1'b1 && rd_n === 1'b1 && dq_oe_out === 1'b0 &&
          {psel_out, ssel_out} === 12'h000, "idle pins");
    rst_in = 1'b0;
    a = 16'($urandom) & 16'hFFFE;
    run(CMD_READ, a, 16'h0000, 8'h01);
    check(rdata_out === 16'hFFFF, "blank read");
    for (int i = 0; i < 6; i++) begin
      be_nxt = 1'($urandom);
      d = 16'($urandom) & 16'h7FFE;
      prog_chk(a + 16'(2 * i), d, (i == 3) ? PMASK : 8'h01);
    end
    prog_chk(a, ~expv(a), 8'h01);
    run(CMD_ID, a, 16'h0000, 8'h01);
    check(rdata_out[7:0] === ID_VAL, "identifier");
    for (int i = 0; i < 2; i++) begin
      run(CMD_RESET, a, 16'h0000, 8'h01);
      run(CMD_PROT, a, 16'h0000, i ? PMASK : 8'h01);
      check(rdata_out[7:0] === 8'(i), "protection");
    end
    run(CMD_RESET, a, 16'h0000, 8'h01);
    run(CMD_READ, a, 16'h0000, 8'h01);
    check(rdata_out === expv(a), "read after reset");
    run(CMD_SERASE, a, 16'h0000, PMASK);
    run(CMD_READ, a, 16'h0000, 8'h01);
    check(rdata_out === expv(a) && error_out === 1'b0, "protected erase");
    for (int i = 0; i < 2; i++) begin
      run(i ? CMD_BERASE : CMD_SERASE, a, 16'h0000, 8'h01);
      ref_mem.delete();
      check(rdata_out === 16'hFFFF && error_out === 1'b0, "erase");
      prog_chk(a, 16'($urandom), 8'h01);
    end
    wrap_up();
  end
endmodule : fsq_flash_host_tb
